// ---- core/rsc_pkg.sv ----
// Constants and types shared by the reset source controller
`default_nettype none
package rsc_pkg;

	localparam int CLK_FREQ_MHZ = 40;
	localparam int T_PIN_MIN_NS = 100;
	// Whole cycles inside the shortest legal pin pulse
	localparam int PIN_MIN_CYC = (T_PIN_MIN_NS * CLK_FREQ_MHZ) / 1000;
	// One cycle given up to the unknown sampling phase of the pin
	localparam int PIN_FILT_CYC = (PIN_MIN_CYC > 1) ? PIN_MIN_CYC - 1 : 1;
	localparam int PIN_CNT_W = 3;
	localparam logic [PIN_CNT_W-1:0] PIN_FILT_MAX = PIN_CNT_W'(PIN_FILT_CYC);
	localparam logic [PIN_CNT_W-1:0] PIN_CNT_ZERO = 3'h0;

	localparam int STRETCH_CYC = 16;
	localparam int STR_CNT_W = 5;
	localparam logic [STR_CNT_W-1:0] STRETCH_LAST = STR_CNT_W'(STRETCH_CYC - 1);
	localparam logic [STR_CNT_W-1:0] STR_CNT_ZERO = 5'h00;
	localparam logic [STR_CNT_W-1:0] STR_CNT_ONE = 5'h01;

	localparam int BOOT_W = 2;
	localparam logic [BOOT_W-1:0] BOOT_RST = 2'h0;

	localparam int CAUSE_W = 5;
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_HW = 1;
	localparam int CAUSE_WDT = 2;
	localparam int CAUSE_WAKE = 3;
	localparam int CAUSE_BOR = 4;
	localparam logic [CAUSE_W-1:0] CAUSE_NONE = 5'h00;
	localparam logic [CAUSE_W-1:0] CAUSE_POR_ONLY = 5'h01;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HOLD = 2'b01,
		ST_STRETCH = 2'b10
	} rsc_state_e;

	// Keeps only the strongest cause: power-on, brownout, wake-up, pin, watchdog
	function automatic logic [CAUSE_W-1:0] rsc_prio(input logic [CAUSE_W-1:0] c);
		logic [CAUSE_W-1:0] r;
		r = CAUSE_NONE;
		if (c[CAUSE_POR]) begin
			r[CAUSE_POR] = 1'b1;
		end else if (c[CAUSE_BOR]) begin
			r[CAUSE_BOR] = 1'b1;
		end else if (c[CAUSE_WAKE]) begin
			r[CAUSE_WAKE] = 1'b1;
		end else if (c[CAUSE_HW]) begin
			r[CAUSE_HW] = 1'b1;
		end else if (c[CAUSE_WDT]) begin
			r[CAUSE_WDT] = 1'b1;
		end
		return r;
	endfunction

endpackage
`default_nettype wire

// ---- core/rsc_reset_ctrl.sv ----
// Reset source controller: merges reset sources, latches boot pins, tracks RAM validity
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl
	import rsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic por_req,
	input wire logic reset_pin_n,
	input wire logic brownout_req,
	input wire logic watchdog_unit_req,
	input wire logic power_down,
	input wire logic [BOOT_W-1:0] boot_pins,
	output logic sys_reset,
	output logic [BOOT_W-1:0] boot_sel,
	output logic [CAUSE_W-1:0] reset_cause,
	output logic ram_kept
);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronisers for everything that comes from outside the clock domain

	logic por_s1_reg, por_s2_reg;
	logic bor_s1_reg, bor_s2_reg;
	logic pin_s1_reg, pin_s2_reg;
	logic [BOOT_W-1:0] boot_s1_reg, boot_s2_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			por_s1_reg <= 1'b0;
			por_s2_reg <= 1'b0;
			bor_s1_reg <= 1'b0;
			bor_s2_reg <= 1'b0;
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			boot_s1_reg <= BOOT_RST;
			boot_s2_reg <= BOOT_RST;
		end else begin
			por_s1_reg <= por_req;
			por_s2_reg <= por_s1_reg;
			bor_s1_reg <= brownout_req;
			bor_s2_reg <= bor_s1_reg;
			pin_s1_reg <= reset_pin_n;
			pin_s2_reg <= pin_s1_reg;
			boot_s1_reg <= boot_pins;
			boot_s2_reg <= boot_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin filter: short glitches are ignored, a legal pulse always qualifies

	logic [PIN_CNT_W-1:0] pin_cnt_reg, pin_cnt_next;
	logic pin_act;

	always_comb begin
		pin_cnt_next = PIN_CNT_ZERO;
		if (!pin_s2_reg) begin
			if (pin_cnt_reg == PIN_FILT_MAX) begin
				pin_cnt_next = PIN_FILT_MAX;
			end else begin
				pin_cnt_next = pin_cnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_cnt_reg <= PIN_CNT_ZERO;
		end else begin
			pin_cnt_reg <= pin_cnt_next;
		end
	end

	// Qualifies within the low pulse the outside driver must provide
	assign pin_act = (pin_cnt_reg == PIN_FILT_MAX);

	////////////////////////////////////////////////////////////////////////////////
	// Source merge and reset sequence

	logic any_src;
	logic [CAUSE_W-1:0] src_cause;

	always_comb begin
		src_cause = CAUSE_NONE;
		src_cause[CAUSE_POR] = por_s2_reg;
		src_cause[CAUSE_BOR] = bor_s2_reg;
		src_cause[CAUSE_WDT] = watchdog_unit_req;
		// Pin reset is accepted in both modes; power-down marks it as wake-up
		src_cause[CAUSE_WAKE] = pin_act & power_down;
		src_cause[CAUSE_HW] = pin_act & ~power_down;
	end

	assign any_src = |src_cause;

	rsc_state_e state_reg, state_next;
	logic [STR_CNT_W-1:0] cnt_reg, cnt_next;
	logic [CAUSE_W-1:0] cause_reg, cause_next;
	logic sys_reset_reg, sys_reset_next;
	logic [BOOT_W-1:0] boot_sel_reg, boot_sel_next;
	logic ram_kept_reg, ram_kept_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cause_next = cause_reg;
		sys_reset_next = sys_reset_reg;
		boot_sel_next = boot_sel_reg;
		ram_kept_next = ram_kept_reg;
		case (state_reg)
			ST_RUN: begin
				if (any_src) begin
					state_next = ST_HOLD;
					sys_reset_next = 1'b1;
					cause_next = rsc_prio(src_cause);
				end
			end
			ST_HOLD: begin
				cause_next = rsc_prio(cause_reg | src_cause);
				if (!any_src) begin
					state_next = ST_STRETCH;
					cnt_next = STR_CNT_ZERO;
				end
			end
			ST_STRETCH: begin
				cause_next = rsc_prio(cause_reg | src_cause);
				if (any_src) begin
					// A fresh source restarts the sequence; reset never drops early
					state_next = ST_HOLD;
				end else if (cnt_reg == STRETCH_LAST) begin
					state_next = ST_RUN;
					sys_reset_next = 1'b0;
					// Watchdog, wake-up and brownout resets keep the boot choice the running code was built on
					if (cause_reg[CAUSE_POR] || cause_reg[CAUSE_HW]) begin
						boot_sel_next = boot_s2_reg;
					end
					// Brownout may corrupt RAM as a power loss does
					if (cause_reg[CAUSE_POR] || cause_reg[CAUSE_BOR]) begin
						ram_kept_next = 1'b0;
					end else if (cause_reg[CAUSE_WAKE]) begin
						ram_kept_next = 1'b1;
					end
				end else begin
					cnt_next = cnt_reg + STR_CNT_ONE;
				end
			end
			default: begin
				state_next = ST_HOLD;
				sys_reset_next = 1'b1;
				cause_next = CAUSE_POR_ONLY;
			end
		endcase
	end

	// The controller's own reset counts as a power-on
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= ST_STRETCH;
			cnt_reg <= STR_CNT_ZERO;
			cause_reg <= CAUSE_POR_ONLY;
			sys_reset_reg <= 1'b1;
			boot_sel_reg <= BOOT_RST;
			ram_kept_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cause_reg <= cause_next;
			sys_reset_reg <= sys_reset_next;
			boot_sel_reg <= boot_sel_next;
			ram_kept_reg <= ram_kept_next;
		end
	end

	assign sys_reset = sys_reset_reg;
	assign boot_sel = boot_sel_reg;
	assign reset_cause = cause_reg;
	assign ram_kept = ram_kept_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	src_reset_a: assert property ((por_s2_reg || bor_s2_reg) |=> sys_reset_reg)
		else $error("power-on or brownout did not reset the device");

	wdt_reset_a: assert property (watchdog_unit_req |=> sys_reset_reg && state_reg != ST_RUN)
		else $error("watchdog request did not reset the device");

	pin_reset_a: assert property ((!pin_s2_reg) [*3] ##1 !pin_s2_reg |=> sys_reset_reg)
		else $error("held reset pin did not reset the device");

	wake_cause_a: assert property ((state_reg == ST_RUN && pin_act && power_down
		&& !por_s2_reg && !bor_s2_reg) |=> cause_reg[CAUSE_WAKE])
		else $error("reset in power-down not recorded as wake-up");

	boot_hold_a: assert property ((!sys_reset_reg && $past(!sys_reset_reg))
		|-> $stable(boot_sel_reg))
		else $error("boot selection changed while running");

	boot_latch_a: assert property ((state_reg == ST_STRETCH && cnt_reg == STRETCH_LAST
		&& !any_src && (cause_reg[CAUSE_POR] || cause_reg[CAUSE_HW]))
		|=> boot_sel_reg == $past(boot_s2_reg) && !sys_reset_reg)
		else $error("boot pins not latched at end of sequence");

	// Brownout counts as a power loss, so it clears RAM validity like power-on
	ram_state_a: assert property ((state_reg == ST_STRETCH && cnt_reg == STRETCH_LAST
		&& !any_src)
		|=> ram_kept_reg == ($past(cause_reg[CAUSE_WAKE]) ? 1'b1
		: (($past(cause_reg[CAUSE_POR]) || $past(cause_reg[CAUSE_BOR])) ? 1'b0
		: $past(ram_kept_reg))))
		else $error("RAM validity wrong after reset sequence");

	reset_release_a: assert property ($fell(sys_reset_reg)
		|-> $past(!any_src, 1) && $past(state_reg, 1) == ST_STRETCH)
		else $error("internal reset released while a source was active");

	// Two runs of eight quiet cycles span the full stretch, then reset must drop
	stretch_len_a: assert property ((state_reg == ST_HOLD && !any_src)
		##1 (!any_src) [*8] ##1 (!any_src) [*8]
		|-> sys_reset_reg ##1 !sys_reset_reg)
		else $error("internal reset shorter than the stretch");

	wake_cov: cover property (state_reg == ST_RUN && pin_act && power_down);
	wdt_cov: cover property (state_reg == ST_RUN && watchdog_unit_req);
	por_boot_cov: cover property ($fell(sys_reset_reg) && cause_reg[CAUSE_POR]);
	restart_cov: cover property (state_reg == ST_STRETCH && any_src);

endmodule

`default_nettype wire

// ---- tb/rsc_pin_driver.sv ----
// Board-side driver of the active-low reset pin
`timescale 1ns/1ps
`default_nettype none

module rsc_pin_driver
	import rsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic hold,
	output logic reset_pin_n
);
	logic pin_q = 1'b1;
	int low_cnt = 0;

	// A short request is still stretched to the legal minimum low time
	always @(posedge ref_clk) begin
		if (hold || (low_cnt != 0 && low_cnt < PIN_MIN_CYC)) begin
			pin_q <= 1'b0;
			low_cnt <= low_cnt + 1;
		end else begin
			pin_q <= 1'b1;
			low_cnt <= 0;
		end
	end

	assign reset_pin_n = pin_q;
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import rsc_pkg::*;
;
	logic ref_clk = 1'b0, rst = 1'b1, por_req = 1'b0, brownout_req = 1'b0;
	logic watchdog_unit_req = 1'b0, power_down = 1'b0, pin_hold = 1'b0;
	logic reset_pin_n, sys_reset, ram_kept;
	logic [BOOT_W-1:0] boot_pins = 2'h0, boot_sel, m_boot;
	logic [CAUSE_W-1:0] reset_cause;
	logic m_ram;
	int fails = 0, checked = 0;
	int n;
	logic [31:0] seed = 32'h000132a1;

	always #12.5 ref_clk = ~ref_clk;

	rsc_pin_driver u_pin (.ref_clk(ref_clk), .hold(pin_hold), .reset_pin_n(reset_pin_n));
	rsc_reset_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .por_req(por_req),
		.reset_pin_n(reset_pin_n), .brownout_req(brownout_req),
		.watchdog_unit_req(watchdog_unit_req), .power_down(power_down),
		.boot_pins(boot_pins), .sys_reset(sys_reset), .boot_sel(boot_sel),
		.reset_cause(reset_cause), .ram_kept(ram_kept));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (exp !== got) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Waits for the end of the sequence, then compares with the model
	// pre: edges already seen with the reset high before this task starts
	task automatic finish_seq(input int k, input int pre);
		n = 0;
		while (sys_reset === 1'b1 && n < 80) begin
			@(posedge ref_clk);
			#1;
			if (sys_reset === 1'b1) n++;
		end
		// Watchdog: one cycle of request, then the full stretch
		if (k == CAUSE_WDT) chk("stretch", 8'(STRETCH_CYC + 1), 8'(pre + n));
		if (k == CAUSE_POR || k == CAUSE_HW) m_boot = boot_pins;
		if (k == CAUSE_POR || k == CAUSE_BOR) m_ram = 1'b0;
		if (k == CAUSE_WAKE) m_ram = 1'b1;
		chk("sys_reset", 8'h00, 8'(sys_reset));
		chk("reset_cause", 8'(1 << k), 8'(reset_cause));
		chk("boot_sel", 8'(m_boot), 8'(boot_sel));
		chk("ram_kept", 8'(m_ram), 8'(ram_kept));
	endtask

	task automatic run_seq(input int k, input int hold);
		seed = xorshift(seed);
		@(posedge ref_clk);
		boot_pins <= seed[BOOT_W-1:0];
		power_down <= (k == CAUSE_WAKE);
		repeat (4) @(posedge ref_clk);
		por_req <= (k == CAUSE_POR);
		pin_hold <= (k == CAUSE_HW || k == CAUSE_WAKE);
		watchdog_unit_req <= (k == CAUSE_WDT);
		brownout_req <= (k == CAUSE_BOR);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			watchdog_unit_req <= 1'b0;
			#1;
		end while (sys_reset !== 1'b1 && n < 20);
		if (k == CAUSE_WDT) chk("wdt_latency", 8'h01, 8'(n));
		repeat (hold) begin
			@(posedge ref_clk);
			#1;
			chk("held", 8'h01, 8'(sys_reset));
		end
		@(posedge ref_clk);
		{por_req, pin_hold, brownout_req} <= 3'h0;
		finish_seq(k, hold + 2);
		@(posedge ref_clk);
		power_down <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(25 * 20000);
		fails++;
		wrap_up();
	end

	initial begin
		m_ram = 1'b0;
		boot_pins = 2'h2;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		finish_seq(CAUSE_POR, 0);
		for (int i = 0; i < 12; i++) begin
			seed = xorshift(seed);
			run_seq((i < 5) ? i : int'(seed[8:6]) % 5, int'(seed[12:10]) + 1);
		end
		// Mid-run controller reset after a wake-up: RAM validity must be lost again
		run_seq(CAUSE_WAKE, 2);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk("rst_sys_reset", 8'h01, 8'(sys_reset));
		chk("rst_ram_kept", 8'h00, 8'(ram_kept));
		m_ram = 1'b0;
		@(posedge ref_clk);
		#1;
		finish_seq(CAUSE_POR, 0);
		run_seq(CAUSE_WDT, 0);
		wrap_up();
	end
endmodule

`default_nettype wire
